/* hdl/tsw_bus_if.sv */
/*
 * Pin-level carrier between the host end and the device end.
 * Assumes the board pull on the acknowledge line follows the strap:
 * pull-up in data-strobe style, pull-down in separate-strobe style.
 */
`timescale 1ns/1ps
interface tsw_bus_if;
    // Reset and strap
    logic                       rst_n;
    logic                       bus_style_strap;
    // Control strobes
    logic                       cs_n;
    logic                       rw_wr_n;
    logic                       strobe_read_line_n;
    logic [tsw_pkg::ADDR_W-1:0] addr;
    // Data bus halves and resolved level
    logic [tsw_pkg::DATA_W-1:0] host_d;
    logic                       host_d_oe;
    logic [tsw_pkg::DATA_W-1:0] dev_d;
    logic                       dev_d_oe;
    logic [tsw_pkg::DATA_W-1:0] data;
    // Acknowledge driver and resolved level
    logic                       xfer_ack_ready_drv;
    logic                       xfer_ack_ready_oe;
    logic                       xfer_ack_ready;

    // Undriven data reads zero; a clash favours the device
    assign data = dev_d_oe ? dev_d : (host_d_oe ? host_d : 16'h0000);
    // Released acknowledge falls back to the board pull
    assign xfer_ack_ready = xfer_ack_ready_oe ? xfer_ack_ready_drv : bus_style_strap;

    modport dev (
        input  rst_n, bus_style_strap, cs_n, rw_wr_n, strobe_read_line_n, addr, data,
        output dev_d, dev_d_oe, xfer_ack_ready_drv, xfer_ack_ready_oe
    );
    modport host (
        input  data, xfer_ack_ready,
        output rst_n, bus_style_strap, cs_n, rw_wr_n, strobe_read_line_n, addr,
        output host_d, host_d_oe
    );
endinterface : tsw_bus_if

/* hdl/tsw_dev_port.sv */
/*
 * Device end of the parallel host port: pin synchronisers, a small
 * register store, the two bus styles and the stream output enables.
 * Assumes the host keeps address and data stable while its strobe is low.
 */
`timescale 1ns/1ps
module tsw_dev_port #(
    parameter int STAB_CYCLES = tsw_pkg::STAB_CYCLES
) (
    // Clock and reset
    input  wire logic                        clk_sys_i,
    input  wire logic                        resetn_i,
    // Host pins
    tsw_bus_if.dev                           bus,
    // Output stream control
    input  wire logic                        out_drive_enable_i,
    output logic [tsw_pkg::STREAMS-1:0]      serial_out_streams_en_o,
    output logic [tsw_pkg::HIZ_N-1:0]        ext_hiz_controls_o
);
    localparam int SYNC_W = 5 + tsw_pkg::ADDR_W + tsw_pkg::DATA_W;
    // Strobes idle high, enable pin idle high (pull-up)
    localparam logic [SYNC_W-1:0] SYNC_RST = {5'h1F, 14'h0000, 16'h0000};
    localparam logic [tsw_pkg::CNT_W-1:0] STAB_END = tsw_pkg::CNT_W'(STAB_CYCLES);

    logic                               arst_n;
    logic [1:0]                         rst_sync;
    logic                               rst_n;
    logic [SYNC_W-1:0]                  sync_a;
    logic [SYNC_W-1:0]                  sync_b;
    logic                               s_strap;
    logic                               s_cs_n;
    logic                               s_rw_n;
    logic                               s_ds_n;
    logic                               s_drive;
    logic [tsw_pkg::ADDR_W-1:0]         s_addr;
    logic [tsw_pkg::DATA_W-1:0]         s_data;

    tsw_pkg::tsw_dev_state_t            state;
    tsw_pkg::tsw_dev_state_t            next_state;
    logic [tsw_pkg::DATA_W-1:0]         store [tsw_pkg::STORE_DEPTH];
    logic [tsw_pkg::DATA_W-1:0]         next_store [tsw_pkg::STORE_DEPTH];
    logic [tsw_pkg::DATA_W-1:0]         rdata;
    logic [tsw_pkg::DATA_W-1:0]         next_rdata;
    logic                               d_oe;
    logic                               next_d_oe;
    logic                               ack;
    logic                               next_ack;
    logic                               ack_oe;
    logic                               next_ack_oe;
    logic                               write_op;
    logic                               next_write_op;
    logic [tsw_pkg::CNT_W-1:0]          cnt;
    logic [tsw_pkg::CNT_W-1:0]          next_cnt;
    logic                               style;
    logic                               next_style;
    logic [tsw_pkg::STREAMS-1:0]        next_streams_en;
    logic [tsw_pkg::HIZ_N-1:0]          next_hiz;
    logic                               stable;
    logic                               sel;
    logic                               strobe_end;
    logic [tsw_pkg::STORE_IDX_W-1:0]    idx;

    // Either reset source; release is synchronised to avoid a split exit
    assign arst_n = resetn_i & bus.rst_n;
    always_ff @(posedge clk_sys_i or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync <= 2'b00;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end
    assign rst_n = rst_sync[1];

    // Two-flop synchroniser for every pin; only sync_b is read
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            sync_a <= SYNC_RST;
            sync_b <= SYNC_RST;
        end else begin
            sync_a <= {bus.bus_style_strap, bus.cs_n, bus.rw_wr_n, bus.strobe_read_line_n,
                       out_drive_enable_i, bus.addr, bus.data};
            sync_b <= sync_a;
        end
    end
    assign {s_strap, s_cs_n, s_rw_n, s_ds_n, s_drive, s_addr, s_data} = sync_b;
    assign idx = s_addr[tsw_pkg::STORE_IDX_W-1:0];

    // Next-state logic for the access engine, store and outputs
    always_comb begin
        next_state    = state;
        next_store    = store;
        next_rdata    = rdata;
        next_write_op = write_op;
        next_cnt      = cnt;
        next_style    = style;
        next_ack      = ack;
        stable = (cnt == STAB_END);
        if (!stable) begin
            next_cnt   = cnt + 16'h0001;
            // strap followed until accesses open, then frozen
            next_style = s_strap;
        end
        sel = !s_cs_n && stable;
        // data-strobe ends on strobe high; separate-strobe on both high
        strobe_end = (style == tsw_pkg::STYLE_DS) ? s_ds_n : (s_ds_n && s_rw_n);
        case (state)
            tsw_pkg::DEV_IDLE: begin
                next_ack = (style == tsw_pkg::STYLE_DS) ? 1'b1 : 1'b0;
                if (sel && !s_ds_n) begin
                    // direction from the style in force
                    next_write_op = (style == tsw_pkg::STYLE_DS) ? !s_rw_n : 1'b0;
                    next_state    = tsw_pkg::DEV_XFER;
                end else if (sel && (style != tsw_pkg::STYLE_DS) && !s_rw_n) begin
                    // write line low starts a write
                    next_write_op = 1'b1;
                    next_state    = tsw_pkg::DEV_XFER;
                end
            end
            tsw_pkg::DEV_XFER: begin
                if (write_op) begin
                    if (tsw_pkg::store_hit(s_addr)) begin
                        next_store[idx] = s_data;
                    end
                end else begin
                    next_rdata = tsw_pkg::store_hit(s_addr) ? store[idx] : 16'h0000;
                end
                next_ack   = (style == tsw_pkg::STYLE_DS) ? 1'b0 : 1'b1;
                next_state = tsw_pkg::DEV_DONE;
            end
            tsw_pkg::DEV_DONE: begin
                // Hold completion until the host lets go
                if (s_cs_n || strobe_end) begin
                    next_ack   = (style == tsw_pkg::STYLE_DS) ? 1'b1 : 1'b0;
                    next_state = tsw_pkg::DEV_IDLE;
                end
            end
            default: begin
                next_state = tsw_pkg::DEV_IDLE;
            end
        endcase
        // data driven only for a read, once data is ready
        next_d_oe   = !s_cs_n && (next_state == tsw_pkg::DEV_DONE) && !next_write_op;
        next_ack_oe = !s_cs_n;
        // outputs on only with pin and control bit both set
        next_streams_en = {tsw_pkg::STREAMS{s_drive &&
            store[tsw_pkg::CTRL_IDX][tsw_pkg::CTRL_OUT_EN]}};
        next_hiz        = ~{tsw_pkg::HIZ_N{next_streams_en[0]}};
    end

    // Registers; reset defaults and cleared counter
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            state                   <= tsw_pkg::DEV_IDLE;
            rdata                   <= 16'h0000;
            d_oe                    <= 1'b0;
            ack                     <= 1'b1;
            ack_oe                  <= 1'b0;
            write_op                <= 1'b0;
            cnt                     <= 16'h0000;
            style                   <= tsw_pkg::STYLE_DS;
            serial_out_streams_en_o <= 16'h0000;
            ext_hiz_controls_o      <= 8'hFF;
            for (int i = 0; i < tsw_pkg::STORE_DEPTH; i++) begin
                store[i] <= tsw_pkg::STORE_RST;
            end
        end else begin
            state                   <= next_state;
            rdata                   <= next_rdata;
            d_oe                    <= next_d_oe;
            ack                     <= next_ack;
            ack_oe                  <= next_ack_oe;
            write_op                <= next_write_op;
            cnt                     <= next_cnt;
            style                   <= next_style;
            serial_out_streams_en_o <= next_streams_en;
            ext_hiz_controls_o      <= next_hiz;
            store                   <= next_store;
        end
    end

    // Pin drivers straight from flops
    assign bus.dev_d              = rdata;
    assign bus.dev_d_oe           = d_oe;
    assign bus.xfer_ack_ready_drv = ack;
    assign bus.xfer_ack_ready_oe  = ack_oe;

endmodule : tsw_dev_port

/* hdl/tsw_host_port.sv */
/*
 * Host end: pulses the device reset, waits out stabilisation, then runs
 * single read or write accesses in the strapped bus style.
 * Assumes one request at a time, offered while req_ready_o is high.
 */
`timescale 1ns/1ps
module tsw_host_port #(
    parameter int STAB_CYCLES = tsw_pkg::STAB_CYCLES
) (
    // Clock and reset
    input  wire logic                        clk_sys_i,
    input  wire logic                        resetn_i,
    // Device pins
    tsw_bus_if.host                          bus,
    // Requests
    input  wire logic                        style_i,
    input  wire logic                        req_valid_i,
    input  wire logic                        req_write_i,
    input  wire logic [tsw_pkg::ADDR_W-1:0]  req_addr_i,
    input  wire logic [tsw_pkg::DATA_W-1:0]  req_wdata_i,
    // Answers
    output logic                             req_ready_o,
    output logic                             done_o,
    output logic [tsw_pkg::DATA_W-1:0]       rdata_o
);
    localparam logic [tsw_pkg::CNT_W-1:0] RST_END  = tsw_pkg::CNT_W'(tsw_pkg::RST_CYCLES);
    localparam logic [tsw_pkg::CNT_W-1:0] STAB_END = tsw_pkg::CNT_W'(STAB_CYCLES);

    tsw_pkg::tsw_host_state_t       state;
    tsw_pkg::tsw_host_state_t       next_state;
    logic [1:0]                     ack_sync;
    logic [tsw_pkg::DATA_W-1:0]     data_sync_a;
    logic [tsw_pkg::DATA_W-1:0]     data_sync_b;
    logic [tsw_pkg::CNT_W-1:0]      cnt;
    logic [tsw_pkg::CNT_W-1:0]      next_cnt;
    logic                           rst_n;
    logic                           next_rst_n;
    logic                           style;
    logic                           next_style;
    logic                           cs_n;
    logic                           next_cs_n;
    logic                           rw_n;
    logic                           next_rw_n;
    logic                           ds_n;
    logic                           next_ds_n;
    logic                           write_op;
    logic                           next_write_op;
    logic [tsw_pkg::ADDR_W-1:0]     addr;
    logic [tsw_pkg::ADDR_W-1:0]     next_addr;
    logic [tsw_pkg::DATA_W-1:0]     wdata;
    logic [tsw_pkg::DATA_W-1:0]     next_wdata;
    logic                           d_oe;
    logic                           next_d_oe;
    logic                           next_ready;
    logic                           next_done;
    logic [tsw_pkg::DATA_W-1:0]     next_rdata;
    logic                           done_level;
    logic                           idle_level;

    // Acknowledge and data pins: two flops each, kept in step
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ack_sync    <= 2'b00;
            data_sync_a <= 16'h0000;
            data_sync_b <= 16'h0000;
        end else begin
            ack_sync    <= {ack_sync[0], bus.xfer_ack_ready};
            data_sync_a <= bus.data;
            data_sync_b <= data_sync_a;
        end
    end

    // Next-state logic for reset sequencing and accesses
    always_comb begin
        next_state    = state;
        next_cnt      = cnt;
        next_rst_n    = rst_n;
        next_style    = style;
        next_cs_n     = cs_n;
        next_rw_n     = rw_n;
        next_ds_n     = ds_n;
        next_write_op = write_op;
        next_addr     = addr;
        next_wdata    = wdata;
        next_d_oe     = d_oe;
        next_done     = 1'b0;
        next_rdata    = rdata_o;
        // completion and idle levels per style
        done_level = (style == tsw_pkg::STYLE_DS) ? 1'b0 : 1'b1;
        idle_level = !done_level;
        case (state)
            tsw_pkg::HOST_RESET: begin
                // device reset held past the minimum
                next_style = style_i;
                next_cnt   = cnt + 16'h0001;
                if (cnt == RST_END) begin
                    next_rst_n = 1'b1;
                    next_cnt   = 16'h0000;
                    next_state = tsw_pkg::HOST_STAB;
                end
            end
            tsw_pkg::HOST_STAB: begin
                next_cnt = cnt + 16'h0001;
                if (cnt == STAB_END) begin
                    next_state = tsw_pkg::HOST_IDLE;
                end
            end
            tsw_pkg::HOST_IDLE: begin
                if (req_valid_i) begin
                    // address and select set up first
                    next_addr     = req_addr_i;
                    next_wdata    = req_wdata_i;
                    next_write_op = req_write_i;
                    next_cs_n     = 1'b0;
                    next_rw_n     = (style == tsw_pkg::STYLE_DS) ? !req_write_i : 1'b1;
                    // host drives data only for a write
                    next_d_oe     = req_write_i;
                    next_state    = tsw_pkg::HOST_SETUP;
                end
            end
            tsw_pkg::HOST_SETUP: begin
                if (style == tsw_pkg::STYLE_DS || !write_op) begin
                    // data strobe or read line low
                    next_ds_n = 1'b0;
                end else begin
                    next_rw_n = 1'b0;
                end
                next_state = tsw_pkg::HOST_WAIT;
            end
            tsw_pkg::HOST_WAIT: begin
                if (ack_sync[1] == done_level) begin
                    next_rdata = write_op ? rdata_o : data_sync_b;
                    next_done  = 1'b1;
                    next_cs_n  = 1'b1;
                    next_ds_n  = 1'b1;
                    next_rw_n  = 1'b1;
                    next_d_oe  = 1'b0;
                    next_state = tsw_pkg::HOST_RELEASE;
                end
            end
            tsw_pkg::HOST_RELEASE: begin
                // Stale completion must clear before the next access
                if (ack_sync[1] == idle_level) begin
                    next_state = tsw_pkg::HOST_IDLE;
                end
            end
            default: begin
                next_state = tsw_pkg::HOST_RESET;
            end
        endcase
        next_ready = (next_state == tsw_pkg::HOST_IDLE);
    end

    // Registers
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state       <= tsw_pkg::HOST_RESET;
            cnt         <= 16'h0000;
            rst_n       <= 1'b0;
            style       <= tsw_pkg::STYLE_DS;
            cs_n        <= 1'b1;
            rw_n        <= 1'b1;
            ds_n        <= 1'b1;
            write_op    <= 1'b0;
            addr        <= 14'h0000;
            wdata       <= 16'h0000;
            d_oe        <= 1'b0;
            req_ready_o <= 1'b0;
            done_o      <= 1'b0;
            rdata_o     <= 16'h0000;
        end else begin
            state       <= next_state;
            cnt         <= next_cnt;
            rst_n       <= next_rst_n;
            style       <= next_style;
            cs_n        <= next_cs_n;
            rw_n        <= next_rw_n;
            ds_n        <= next_ds_n;
            write_op    <= next_write_op;
            addr        <= next_addr;
            wdata       <= next_wdata;
            d_oe        <= next_d_oe;
            req_ready_o <= next_ready;
            done_o      <= next_done;
            rdata_o     <= next_rdata;
        end
    end

    // Pin drivers straight from flops
    assign bus.rst_n              = rst_n;
    assign bus.bus_style_strap    = style;
    assign bus.cs_n               = cs_n;
    assign bus.rw_wr_n            = rw_n;
    assign bus.strobe_read_line_n = ds_n;
    assign bus.addr               = addr;
    assign bus.host_d             = wdata;
    assign bus.host_d_oe          = d_oe;

endmodule : tsw_host_port

/* hdl/tsw_pkg.sv */
/*
 * Shared constants and types for the TDM switch host port: both the device
 * end and the host end import nothing and refer to names here by package.
 * Assumes a single 20 MHz system clock on both ends.
 */
// What this block does
// - 16-bit data bus, device drives only reads
// - host presents 14-bit address every access
// - data-strobe style: acknowledge driven low completes
// - separate-strobe style: acknowledge rising edge completes
// - host asserts low port select per access
// - direction line sets data bus direction
// - data-strobe style: direction high read, low write
// - separate-strobe style: write line low means write
// - data-strobe style: strobe with select starts access
// - separate-strobe style: read line low means read
// - strap high/open data-strobe, low separate-strobe
// - reset loads defaults, clears all counters
// - reset disables streams, forces high-impedance controls high
// - reset held low longer than one microsecond
// - no access for 600 us after reset
// - port reads and writes internal registers, memories
package tsw_pkg;

    // Bus and output widths
    localparam int DATA_W      = 16;
    localparam int ADDR_W      = 14;
    localparam int STREAMS     = 16;
    localparam int HIZ_N       = 8;

    // Internal store: low address bits index it, the rest must be zero
    localparam int STORE_DEPTH = 16;
    localparam int STORE_IDX_W = 4;
    localparam int CTRL_IDX    = 0;
    localparam int CTRL_OUT_EN = 2;
    localparam logic [DATA_W-1:0] STORE_RST = 16'h0000;

    // Timing: 20 MHz system clock
    localparam int CLK_MHZ      = 20;
    localparam int CLK_NS       = 50;
    localparam int RST_HOLD_NS  = 1000;
    localparam int STAB_US      = 600;
    // Reset must be longer than the minimum, hence one cycle beyond
    localparam int RST_CYCLES   = RST_HOLD_NS / CLK_NS + 1;
    localparam int STAB_CYCLES  = STAB_US * CLK_MHZ;
    localparam int CNT_W        = 16;

    // Strap level selecting data-strobe style
    localparam logic STYLE_DS = 1'b1;

    typedef enum logic [1:0] {
        DEV_IDLE,
        DEV_XFER,
        DEV_DONE
    } tsw_dev_state_t;

    typedef enum logic [2:0] {
        HOST_RESET,
        HOST_STAB,
        HOST_IDLE,
        HOST_SETUP,
        HOST_WAIT,
        HOST_RELEASE
    } tsw_host_state_t;

    // Address falls inside the internal store
    function automatic logic store_hit(input logic [ADDR_W-1:0] addr);
        store_hit = (addr[ADDR_W-1:STORE_IDX_W] == '0);
    endfunction : store_hit

endpackage : tsw_pkg

/* tb/tb_tdm_switch_host_port.sv */
/*
 * Self-checking bench: host end and device end joined by the carrier.
 * Assumes a short quiet time parameter; inputs change on falling edges.
 */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; \
    $display("ERROR %s expected %h seen %h", nm, e, g); end end
module tb_tdm_switch_host_port;
    localparam int STAB = 40;
    logic                         clk_sys_i, resetn_i, style, req_valid, req_write, out_drive_enable;
    logic                         ready, done;
    logic [tsw_pkg::ADDR_W-1:0]   req_addr;
    logic [tsw_pkg::DATA_W-1:0]   req_wdata, rdata;
    logic [tsw_pkg::STREAMS-1:0]  streams_en;
    logic [tsw_pkg::HIZ_N-1:0]    hiz;
    logic [tsw_pkg::DATA_W-1:0]   mem [16];
    logic [31:0]                  lfsr;
    int                           error_cnt, compares;

    tsw_bus_if bus_if ();
    tsw_dev_port #(.STAB_CYCLES(STAB)) tsw_dev_port_inst (.clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i), .bus(bus_if.dev), .out_drive_enable_i(out_drive_enable),
        .serial_out_streams_en_o(streams_en), .ext_hiz_controls_o(hiz));
    tsw_host_port #(.STAB_CYCLES(STAB)) tsw_host_port_inst (.clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i), .bus(bus_if.host), .style_i(style), .req_valid_i(req_valid),
        .req_write_i(req_write), .req_addr_i(req_addr), .req_wdata_i(req_wdata),
        .req_ready_o(ready), .done_o(done), .rdata_o(rdata));
    tsw_port_checker #(.STAB_CYCLES(STAB)) tsw_port_checker_inst (.clk_sys_i(clk_sys_i),
        .resetn_i(resetn_i), .rst_n(bus_if.rst_n), .bus_style_strap(bus_if.bus_style_strap),
        .cs_n(bus_if.cs_n), .rw_wr_n(bus_if.rw_wr_n),
        .strobe_read_line_n(bus_if.strobe_read_line_n), .host_d_oe(bus_if.host_d_oe),
        .dev_d_oe(bus_if.dev_d_oe), .xfer_ack_ready_drv(bus_if.xfer_ack_ready_drv),
        .xfer_ack_ready_oe(bus_if.xfer_ack_ready_oe), .xfer_ack_ready(bus_if.xfer_ack_ready));

    // 20 MHz clock
    initial begin
        clk_sys_i = 1'b0;
        forever #25 clk_sys_i = ~clk_sys_i;
    end

    function automatic logic [31:0] next_lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : next_lfsr
    // Unmapped addresses read as zero
    function automatic logic [15:0] exp_read(input logic [13:0] a);
        return (a < 14'h0010) ? mem[a[3:0]] : 16'h0000;
    endfunction : exp_read

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : report_and_stop

    // Stream enables follow control bit 2 and the drive enable pin
    task automatic check_out();
        logic en;
        en = mem[0][2] & out_drive_enable;
        repeat (8) @(negedge clk_sys_i);
        `CHK("streams", {16{en}}, streams_en)
        `CHK("hiz", {8{~en}}, hiz)
    endtask : check_out

    // Reset also chooses the bus style; the store model clears with it
    task automatic do_reset(input logic st);
        resetn_i = 1'b0;
        style = st;
        repeat (3) @(negedge clk_sys_i);
        `CHK("streams", 16'h0000, streams_en)
        `CHK("hiz", 8'hFF, hiz)
        resetn_i = 1'b1;
        foreach (mem[i]) mem[i] = 16'h0000;
    endtask : do_reset

    // One access; waits are bounded so a silent end cannot hang us
    task automatic access(input logic w, input logic [13:0] a, input logic [15:0] d);
        int n;
        n = 0;
        while (ready !== 1'b1 && n < 300) begin @(negedge clk_sys_i); n++; end
        req_valid = 1'b1;
        req_write = w;
        req_addr = a;
        req_wdata = d;
        @(negedge clk_sys_i);
        req_valid = 1'b0;
        n = 0;
        while (done !== 1'b1 && n < 60) begin @(negedge clk_sys_i); n++; end
        `CHK("done", 1'b1, done)
        if (!w) `CHK("rdata", exp_read(a), rdata)
        if (w && a < 14'h0010) mem[a[3:0]] = d;
    endtask : access

    // Watchdog
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        error_cnt++;
        $display("ERROR watchdog expected finish seen hang");
        report_and_stop();
    end

    // Main sequence: data-strobe style, then separate strobes
    initial begin
        {resetn_i, req_valid, req_write, req_addr, req_wdata} = '0;
        style = 1'b1;
        out_drive_enable = 1'b1;
        lfsr = 32'hA782;
        for (int s = 0; s < 2; s++) begin
            do_reset(s == 0);
            for (int a = 0; a < 16; a++) access(1'b0, 14'(a), 16'h0000);
            `CHK("strap", style, bus_if.bus_style_strap)
            $display("test reset_values finished");
            access(1'b1, 14'h0000, 16'h0004);
            check_out();
            out_drive_enable = 1'b0;
            check_out();
            out_drive_enable = 1'b1;
            check_out();
            $display("test output_enable finished");
            access(1'b1, 14'h0005, 16'hA5C3);
            access(1'b0, 14'h0005, 16'h0000);
            access(1'b1, 14'h3FFF, 16'hFFFF);
            access(1'b0, 14'h3FFF, 16'h0000);
            $display("test corners finished");
            repeat (24) begin
                lfsr = next_lfsr(lfsr);
                access(lfsr[0], {9'h000, lfsr[5:1]}, lfsr[31:16]);
            end
            $display("test random finished");
        end
        report_and_stop();
    end
endmodule : tb_tdm_switch_host_port

/* tb/tsw_port_assertions.sv */
/*
 * Pin-level checker for the host port, fed from the carrier's signals.
 * Assumes one 20 MHz clock and the bench reset resetn_i, low active.
 */
`timescale 1ns/1ps
module tsw_port_checker #(
    parameter int STAB_CYCLES = tsw_pkg::STAB_CYCLES
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    // Carrier signals
    input wire logic rst_n,
    input wire logic bus_style_strap,
    input wire logic cs_n,
    input wire logic rw_wr_n,
    input wire logic strobe_read_line_n,
    input wire logic host_d_oe,
    input wire logic dev_d_oe,
    input wire logic xfer_ack_ready_drv,
    input wire logic xfer_ack_ready_oe,
    input wire logic xfer_ack_ready
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!resetn_i);
    logic [15:0] stab_cnt;
    logic [15:0] next_stab_cnt;

    // Quiet time since device reset, saturating
    always_comb begin
        next_stab_cnt = stab_cnt;
        if (!rst_n) next_stab_cnt = 16'h0000;
        else if (stab_cnt < 16'(STAB_CYCLES)) next_stab_cnt = stab_cnt + 16'h0001;
    end
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) stab_cnt <= 16'h0000;
        else stab_cnt <= next_stab_cnt;
    end

    property p_read_only; dev_d_oe |-> rw_wr_n; endproperty
    a_read_only: assert property (p_read_only) else $error("device drives data on write");
    property p_no_clash; !(dev_d_oe && host_d_oe); endproperty
    a_no_clash: assert property (p_no_clash) else $error("both ends drive data");
    property p_ds_ack;
        bus_style_strap && $fell(xfer_ack_ready) |-> !$past(cs_n, 2) && !$past(strobe_read_line_n, 2);
    endproperty
    a_ds_ack: assert property (p_ds_ack) else $error("acknowledge low without strobe");
    property p_ss_ack;
        !bus_style_strap && $rose(xfer_ack_ready)
            |-> !$past(cs_n, 2) && (!$past(strobe_read_line_n, 2) || !$past(rw_wr_n, 2));
    endproperty
    a_ss_ack: assert property (p_ss_ack) else $error("ready rise without strobe");
    property p_ds_start; bus_style_strap && $fell(strobe_read_line_n) |-> !cs_n; endproperty
    a_ds_start: assert property (p_ds_start) else $error("strobe without select");
    property p_reset_quiet; !rst_n |-> !dev_d_oe && !xfer_ack_ready_oe; endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("device drives in reset");
    property p_reset_long; $rose(rst_n) |-> !$past(rst_n, 21); endproperty
    a_reset_long: assert property (p_reset_long) else $error("device reset too short");
    property p_stab_gap; rst_n && stab_cnt < 16'(STAB_CYCLES) |-> cs_n; endproperty
    a_stab_gap: assert property (p_stab_gap) else $error("access during quiet time");
    property p_release; cs_n [*5] |-> !dev_d_oe && !xfer_ack_ready_oe; endproperty
    a_release: assert property (p_release) else $error("pins held while deselected");
    property p_ack_bound;
        $fell(cs_n) |-> ##[2:24] (xfer_ack_ready_oe && xfer_ack_ready_drv != bus_style_strap);
    endproperty
    a_ack_bound: assert property (p_ack_bound) else $error("access never completed");
endmodule : tsw_port_checker
